// ==== hdl/esc_pkg.sv ====
// Purpose: shared constants and types for the exposure sync controller
// Assumes: 10 MHz mclk, 32-bit Avalon-MM register port
package esc_pkg;
   // register byte offsets
   localparam logic [4:0] ESC_OFS_CTRL = 5'h00;
   localparam logic [4:0] ESC_OFS_CMD = 5'h04;
   localparam logic [4:0] ESC_OFS_STATUS = 5'h08;
   localparam logic [4:0] ESC_OFS_IRQ_STAT = 5'h0c;
   localparam logic [4:0] ESC_OFS_IRQ_MASK = 5'h10;
   // control fields
   localparam int ESC_CTRL_W = 7;
   localparam logic [6:0] ESC_CTRL_RST = 7'h04;
   localparam int ESC_CTRL_MODE_LO = 0;
   localparam int ESC_CTRL_PREP_HIGH = 2;
   localparam int ESC_CTRL_PRE_OFS = 3;
   localparam int ESC_CTRL_POST_OFS = 4;
   localparam int ESC_CTRL_GAIN = 5;
   localparam int ESC_CTRL_DEFECT = 6;
   // command bits
   localparam int ESC_CMD_CLEAR = 0;
   localparam int ESC_CMD_ACQUIRE = 1;
   localparam int ESC_CMD_ABORT = 2;
   // event bits, shared by status and mask
   localparam int ESC_EV_W = 6;
   localparam int ESC_EV_PROHIB = 0;
   localparam int ESC_EV_ENABLE = 1;
   localparam int ESC_EV_TIMEOUT = 2;
   localparam int ESC_EV_IMG_START = 3;
   localparam int ESC_EV_IMG_DONE = 4;
   localparam int ESC_EV_ABORT = 5;
   localparam logic [5:0] ESC_MASK_RST = 6'h00;
   // window timeout
   localparam int ESC_CLK_HZ = 10000000;
   localparam int ESC_WIN_TIMEOUT_MS = 5000;
   localparam int ESC_WIN_CYC = ESC_WIN_TIMEOUT_MS * (ESC_CLK_HZ / 1000);
   localparam int ESC_TMR_W = 32;
   // synchronisation modes
   typedef enum logic [1:0] {
      ESC_MODE_HOST = 2'h0,
      ESC_MODE_PREP = 2'h1,
      ESC_MODE_SELF = 2'h2,
      ESC_MODE_SENSOR = 2'h3
   } esc_mode_t;
   // jobs handed to the imaging core
   typedef enum logic [3:0] {
      ESC_JOB_CLEAR = 4'h0,
      ESC_JOB_PREP = 4'h1,
      ESC_JOB_ACQ = 4'h2,
      ESC_JOB_OFFSET = 4'h3,
      ESC_JOB_DARK = 4'h4,
      ESC_JOB_CORRECT = 4'h5,
      ESC_JOB_XFER_FINAL = 4'h6,
      ESC_JOB_XFER_PREVIEW = 4'h7,
      ESC_JOB_XFER_PROC = 4'h8
   } esc_job_t;
   // sequencer states
   typedef enum logic [3:0] {
      ESC_ST_IDLE = 4'h0,
      ESC_ST_CLEAR = 4'h1,
      ESC_ST_PREP = 4'h2,
      ESC_ST_WIN = 4'h3,
      ESC_ST_ACQ = 4'h4,
      ESC_ST_OFFS = 4'h5,
      ESC_ST_XFER1 = 4'h6,
      ESC_ST_DARK = 4'h7,
      ESC_ST_CORR = 4'h8,
      ESC_ST_XFER2 = 4'h9
   } esc_state_t;
endpackage : esc_pkg

// ==== hdl/esc_sync2.sv ====
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module esc_sync2 #(
   parameter int W = 2
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // two flops in a row
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : esc_sync2

// ==== hdl/esc_tmr_if.sv ====
// Purpose: carrier between sequencer and exposure window timer
// Assumes: one clock domain
// Notes: start and stop are one-cycle pulses
`timescale 1ns/1ps
interface esc_tmr_if;
   logic start;
   logic stop;
   logic expired;
   modport seq (output start, output stop, input expired);
   modport tmr (input start, input stop, output expired);
endinterface : esc_tmr_if

// ==== hdl/esc_top.sv ====
// Purpose: exposure sync and acquisition sequencer with register port
// Assumes: imaging core on mclk answers each job with a job_done pulse
// Notes: one job runs at a time; job_code stands until the next job
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module esc_top
   import esc_pkg::*;
#(
   parameter logic [ESC_TMR_W-1:0] WIN_CYC = ESC_TMR_W'(ESC_WIN_CYC)
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // interrupt
   output logic irq,
   // generator and sensor pins
   input wire logic prep_in,
   input wire logic xray_sense_in,
   output logic exposure_inhibit,
   output logic exposure_enable,
   // imaging core jobs
   output logic job_start,
   output logic [3:0] job_code,
   input wire logic job_done
);
   esc_tmr_if tif ();
   esc_state_t state_reg, state_next;
   logic [ESC_CTRL_W-1:0] ctrl_reg;
   logic [ESC_EV_W-1:0] stat_reg, mask_reg, ev_next;
   logic [2:0] cmd_reg;
   logic wait_reg;
   logic [1:0] pin_sync;
   logic prep_act, prep_act_reg, sense_reg;
   logic prep_rise, prep_fall, sense_rise;
   logic stat_rd, acc;
   esc_mode_t mode;
   logic post_sel, ofs_sel;

   // pins through two flops
   esc_sync2 #(.W(2)) u_sync (
      .mclk(mclk),
      .nrst(nrst),
      .d({xray_sense_in, prep_in}),
      .q(pin_sync)
   );

   esc_win_timer #(.TW(ESC_TMR_W), .WIN_CYC(WIN_CYC)) u_tmr (
      .mclk(mclk),
      .nrst(nrst),
      .tif(tif)
   );

   // control field views
   assign mode = esc_mode_t'(ctrl_reg[ESC_CTRL_MODE_LO +: 2]);
   assign post_sel = ctrl_reg[ESC_CTRL_POST_OFS];
   assign ofs_sel = ctrl_reg[ESC_CTRL_PRE_OFS] | ctrl_reg[ESC_CTRL_POST_OFS];
   assign prep_act = (pin_sync[0] == ctrl_reg[ESC_CTRL_PREP_HIGH]);
   assign prep_rise = prep_act & ~prep_act_reg;
   assign prep_fall = ~prep_act & prep_act_reg;
   assign sense_rise = pin_sync[1] & ~sense_reg;
   assign acc = (avs_read | avs_write) & wait_reg;
   assign stat_rd = acc & avs_read & (avs_address == ESC_OFS_IRQ_STAT);

   // job to run in each busy state
   function automatic logic [3:0] job_of(input esc_state_t s, input logic preview);
      case (s)
         ESC_ST_CLEAR: job_of = ESC_JOB_CLEAR;
         ESC_ST_PREP: job_of = ESC_JOB_PREP;
         ESC_ST_ACQ: job_of = ESC_JOB_ACQ;
         ESC_ST_OFFS: job_of = ESC_JOB_OFFSET;
         ESC_ST_DARK: job_of = ESC_JOB_DARK;
         ESC_ST_CORR: job_of = ESC_JOB_CORRECT;
         ESC_ST_XFER1: job_of = preview ? ESC_JOB_XFER_PREVIEW : ESC_JOB_XFER_FINAL;
         ESC_ST_XFER2: job_of = ESC_JOB_XFER_PROC;
         default: job_of = ESC_JOB_CLEAR;
      endcase
   endfunction : job_of

   // states that hand a job to the core
   function automatic logic is_busy(input esc_state_t s);
      is_busy = (s != ESC_ST_IDLE) && (s != ESC_ST_WIN);
   endfunction : is_busy

   // sequencer next state and events
   always_comb begin
      state_next = state_reg;
      ev_next = '0;
      case (state_reg)
         ESC_ST_IDLE: begin
            if (mode == ESC_MODE_PREP) begin
               if (prep_rise) begin
                  state_next = ESC_ST_PREP;
                  ev_next[ESC_EV_PROHIB] = 1'b1;
               end
            end else if (mode == ESC_MODE_SELF) begin
               if (sense_rise) begin
                  state_next = ESC_ST_ACQ;
                  ev_next[ESC_EV_PROHIB] = 1'b1;
               end
            end else if (cmd_reg[ESC_CMD_CLEAR]) begin
               state_next = ESC_ST_CLEAR;
               ev_next[ESC_EV_PROHIB] = 1'b1;
            end
         end
         ESC_ST_CLEAR, ESC_ST_PREP: begin
            if (job_done) begin
               state_next = ESC_ST_WIN;
               ev_next[ESC_EV_ENABLE] = 1'b1;
            end
         end
         ESC_ST_WIN: begin
            if (cmd_reg[ESC_CMD_ABORT]) begin
               state_next = ESC_ST_IDLE;
               ev_next[ESC_EV_ABORT] = 1'b1;
            end else if (tif.expired) begin
               state_next = ESC_ST_ACQ;
               ev_next[ESC_EV_TIMEOUT] = 1'b1;
            end else if (mode == ESC_MODE_HOST && cmd_reg[ESC_CMD_ACQUIRE]) begin
               state_next = ESC_ST_ACQ;
            end else if (mode == ESC_MODE_SENSOR && sense_rise) begin
               state_next = ESC_ST_ACQ;
            end else if (mode == ESC_MODE_PREP && prep_fall) begin
               state_next = ESC_ST_ACQ;
            end
         end
         ESC_ST_ACQ: begin
            if (cmd_reg[ESC_CMD_ABORT] && mode != ESC_MODE_SELF) begin
               state_next = ESC_ST_IDLE;
               ev_next[ESC_EV_ABORT] = 1'b1;
            end else if (job_done) begin
               ev_next[ESC_EV_IMG_START] = 1'b1;
               if (mode == ESC_MODE_SELF && ofs_sel) begin
                  state_next = ESC_ST_OFFS;
               end else begin
                  state_next = ESC_ST_XFER1;
               end
            end
         end
         ESC_ST_OFFS: begin
            if (job_done) begin
               state_next = ESC_ST_XFER1;
            end
         end
         ESC_ST_XFER1: begin
            if (job_done) begin
               if (post_sel || mode == ESC_MODE_SELF) begin
                  state_next = ESC_ST_DARK;
               end else begin
                  state_next = ESC_ST_IDLE;
                  ev_next[ESC_EV_IMG_DONE] = 1'b1;
               end
            end
         end
         ESC_ST_DARK: begin
            if (job_done) begin
               state_next = ESC_ST_CORR;
            end
         end
         ESC_ST_CORR: begin
            if (job_done) begin
               state_next = ESC_ST_XFER2;
            end
         end
         ESC_ST_XFER2: begin
            if (job_done) begin
               state_next = ESC_ST_IDLE;
               ev_next[ESC_EV_IMG_DONE] = 1'b1;
               if (mode == ESC_MODE_SELF) begin
                  ev_next[ESC_EV_ENABLE] = 1'b1;
               end
            end
         end
         default: state_next = ESC_ST_IDLE;
      endcase
   end

   // state and edge history
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_reg <= ESC_ST_IDLE;
         prep_act_reg <= 1'b0;
         sense_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         prep_act_reg <= prep_act;
         sense_reg <= pin_sync[1];
      end
   end

   // job hand-off to the imaging core
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         job_start <= 1'b0;
         job_code <= ESC_JOB_CLEAR;
      end else begin
         job_start <= (state_next != state_reg) && is_busy(state_next);
         if ((state_next != state_reg) && is_busy(state_next)) begin
            job_code <= job_of(state_next, post_sel || mode == ESC_MODE_SELF);
         end
      end
   end

   // generator outputs
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         exposure_inhibit <= 1'b0;
         exposure_enable <= 1'b0;
      end else begin
         exposure_inhibit <= is_busy(state_next);
         exposure_enable <= (state_next == ESC_ST_WIN);
      end
   end

   // window timer control
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tif.start <= 1'b0;
         tif.stop <= 1'b0;
      end else begin
         tif.start <= (state_next == ESC_ST_WIN) && (state_reg != ESC_ST_WIN);
         tif.stop <= (state_reg == ESC_ST_WIN) && (state_next != ESC_ST_WIN);
      end
   end

   // bus: answer one cycle after the request is seen
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wait_reg <= 1'b1;
         avs_readdata <= '0;
      end else if (acc) begin
         wait_reg <= 1'b0;
         avs_readdata <= '0;
         if (avs_read) begin
            case (avs_address)
               ESC_OFS_CTRL: avs_readdata <= {25'h0, ctrl_reg};
               ESC_OFS_STATUS: avs_readdata <= {26'h0, exposure_enable, exposure_inhibit,
                                                state_reg};
               ESC_OFS_IRQ_STAT: avs_readdata <= {26'h0, stat_reg};
               ESC_OFS_IRQ_MASK: avs_readdata <= {26'h0, mask_reg};
               default: avs_readdata <= '0;
            endcase
         end
      end else begin
         wait_reg <= 1'b1;
      end
   end
   assign avs_waitrequest = wait_reg;

   // configuration writes
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ctrl_reg <= ESC_CTRL_RST;
         mask_reg <= ESC_MASK_RST;
      end else if (acc && avs_write && avs_byteenable[0]) begin
         if (avs_address == ESC_OFS_CTRL) begin
            ctrl_reg <= avs_writedata[ESC_CTRL_W-1:0];
         end
         if (avs_address == ESC_OFS_IRQ_MASK) begin
            mask_reg <= avs_writedata[ESC_EV_W-1:0];
         end
      end
   end

   // command pulses, one cycle each
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cmd_reg <= '0;
      end else if (acc && avs_write && avs_byteenable[0] && avs_address == ESC_OFS_CMD) begin
         cmd_reg <= avs_writedata[2:0];
      end else begin
         cmd_reg <= '0;
      end
   end

   // sticky events, set wins over read clear
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         stat_reg <= '0;
         irq <= 1'b0;
      end else begin
         stat_reg <= (stat_rd ? '0 : stat_reg) | ev_next;
         irq <= |(((stat_rd ? '0 : stat_reg) | ev_next) & mask_reg);
      end
   end
endmodule : esc_top

// ==== hdl/esc_win_timer.sv ====
// Purpose: exposure window timeout counter
// Assumes: start and stop never in the same cycle
// Notes: expired pulses once per started window that is not stopped before the count runs out
`timescale 1ns/1ps
module esc_win_timer #(
   parameter int TW = 32,
   parameter logic [TW-1:0] WIN_CYC = 32'h3e8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // control
   esc_tmr_if.tmr tif
);
   logic [TW-1:0] cnt_reg;
   logic run_reg;
   logic exp_reg;

   assign tif.expired = exp_reg;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         exp_reg <= 1'b0;
      end else begin
         exp_reg <= 1'b0;
         if (tif.start) begin
            cnt_reg <= WIN_CYC - 1'b1;
            run_reg <= 1'b1;
         end else if (tif.stop) begin
            run_reg <= 1'b0;
         end else if (run_reg) begin
            if (cnt_reg == '0) begin
               run_reg <= 1'b0;
               exp_reg <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - 1'b1;
            end
         end
      end
   end
endmodule : esc_win_timer

// ==== verification/esc_core_model.sv ====
// Purpose: imaging core stand-in that ends each job
// Assumes: job_start is a one-cycle pulse on mclk
// Notes: lat sets the answer delay, 0 answers fastest
`timescale 1ns/1ps
module esc_core_model (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // job link
   input wire logic job_start,
   input wire logic [3:0] lat,
   output logic job_done
);
   logic [4:0] cnt_reg;
   // count down from job start, pulse done at the end
   always @(posedge mclk) begin
      if (!nrst) begin
         cnt_reg <= 5'h00;
         job_done <= 1'b0;
      end else begin
         job_done <= (cnt_reg == 5'h01);
         if (job_start)
            cnt_reg <= {1'b0, lat} + 5'h01;
         else if (cnt_reg != 5'h00)
            cnt_reg <= cnt_reg - 5'h01;
      end
   end
endmodule : esc_core_model

// ==== verification/esc_top_chk.sv ====
// Purpose: port assertions for the exposure sync controller
// Assumes: one mclk domain, synchronous active-low reset
// Notes: window bound allows a few cycles past WIN_CYC
`timescale 1ns/1ps
module esc_top_chk
   import esc_pkg::*;
#(
   parameter logic [ESC_TMR_W-1:0] WIN_CYC = ESC_TMR_W'(ESC_WIN_CYC)
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // bus handshake
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // pins and job link
   input wire logic exposure_inhibit,
   input wire logic exposure_enable,
   input wire logic job_start,
   input wire logic [3:0] job_code,
   input wire logic job_done
);
   logic [ESC_TMR_W-1:0] win_cnt_reg;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   // length of the open exposure window
   always_ff @(posedge mclk) begin
      if (!nrst || !exposure_enable)
         win_cnt_reg <= 32'h0;
      else
         win_cnt_reg <= win_cnt_reg + 32'h1;
   end
   sequence s_done(logic [3:0] c);
      exposure_inhibit && job_done && job_code == c;
   endsequence
   property p_next(logic [3:0] c, logic [3:0] n);
      s_done(c) |=> job_start && job_code == n;
   endproperty
   property p_open(logic [3:0] c);
      s_done(c) |=> exposure_enable && !exposure_inhibit;
   endproperty
   AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered next cycle");
   AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   AST_CLR_PROHIB: assert property (
      job_start && job_code == ESC_JOB_CLEAR |-> exposure_inhibit && !exposure_enable)
      else $error("clear started without inhibit");
   AST_CLR_ENABLE: assert property (p_open(ESC_JOB_CLEAR))
      else $error("window not open after clear");
   AST_ACQ_NEXT: assert property (s_done(ESC_JOB_ACQ) |=> job_start && job_code inside
      {ESC_JOB_XFER_FINAL, ESC_JOB_XFER_PREVIEW, ESC_JOB_OFFSET})
      else $error("no upload after acquisition");
   AST_FINAL_IDLE: assert property (
      s_done(ESC_JOB_XFER_FINAL) |=> (!exposure_inhibit && !job_start) [*2])
      else $error("work after final upload");
   AST_PREV_DARK: assert property (p_next(ESC_JOB_XFER_PREVIEW, ESC_JOB_DARK))
      else $error("no dark frame after preview");
   AST_DARK_CORR: assert property (p_next(ESC_JOB_DARK, ESC_JOB_CORRECT))
      else $error("no correction after dark frame");
   AST_CORR_PROC: assert property (p_next(ESC_JOB_CORRECT, ESC_JOB_XFER_PROC))
      else $error("no processed upload after correction");
   AST_JOB_INHIBIT: assert property (job_start |-> exposure_inhibit ##1 !job_start)
      else $error("job without inhibit or long start");
   AST_PREP_ENABLE: assert property (p_open(ESC_JOB_PREP))
      else $error("window not open after preparation");
   AST_WIN_CAUSE: assert property ($rose(exposure_enable) |-> $past(job_done))
      else $error("window opened without a finished job");
   AST_NO_OVERLAP: assert property (!(exposure_inhibit && exposure_enable))
      else $error("inhibit and enable together");
   AST_WIN_LIMIT: assert property (win_cnt_reg <= WIN_CYC + 32'h8)
      else $error("window outlived its timeout");
endmodule : esc_top_chk

bind esc_top esc_top_chk #(.WIN_CYC(WIN_CYC)) u_chk (.mclk(mclk), .nrst(nrst),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .exposure_inhibit(exposure_inhibit), .exposure_enable(exposure_enable),
   .job_start(job_start), .job_code(job_code), .job_done(job_done));

// ==== verification/tb_esc_top.sv ====
// Purpose: self-checking bench for the exposure sync controller
// Assumes: core model answers every job, 50-cycle window
// Notes: drivers queue expected values, a monitor compares them
`timescale 1ns/1ps
module tb_esc_top;
   import esc_pkg::*;
   logic mclk, nrst, avs_read, avs_write, avs_waitrequest, irq, prep_in, xray_sense_in;
   logic exposure_inhibit, exposure_enable, job_start, job_done, irq_on;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable, job_code, core_lat;
   logic [63:0] exp_rd[$];
   logic [3:0] exp_job[$];
   int n_mismatch = 0;
   int comparisons = 0;

   esc_top #(.WIN_CYC(32'h32)) dut (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .prep_in(prep_in),
      .xray_sense_in(xray_sense_in), .exposure_inhibit(exposure_inhibit),
      .exposure_enable(exposure_enable), .job_start(job_start), .job_code(job_code),
      .job_done(job_done));
   esc_core_model u_core (.mclk(mclk), .nrst(nrst), .job_start(job_start), .lat(core_lat),
      .job_done(job_done));

   // free-running 10 MHz clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // compare tasks, one per kind of result
   task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk_val
   task automatic chk_job(input logic [3:0] e, input logic [3:0] s);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error job_code expected %h seen %h", e, s);
      end
   endtask : chk_job
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop

   // monitor: oldest note against each read answer and each job start
   always @(posedge mclk) begin
      logic [63:0] n;
      if (nrst && avs_read && avs_waitrequest === 1'b0) begin
         n = exp_rd.size() ? exp_rd.pop_front() : {32'h0, 32'hffffffff};
         chk_val("readdata", n[63:32], avs_readdata & n[31:0]);
      end
      if (nrst && job_start === 1'b1)
         chk_job(exp_job.size() ? exp_job.pop_front() : 4'hf, job_code);
   end

   // one bus cycle, held until waitrequest is sampled low
   task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
         input logic [3:0] be);
      int k;
      k = 0;
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      avs_byteenable <= be;
      do begin
         @(posedge mclk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      if (k >= 50)
         chk_val("waitrequest", 32'h0, 32'h1);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask : bus
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_rd.push_back({e, m});
      bus(a, 1'b0, 32'h0, 4'hf);
   endtask : rd
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 4'hf);
   endtask : wr
   // wait for an open window, or for idle with all jobs seen
   task automatic wt(input logic en);
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (k < 600 && !(en ? exposure_enable === 1'b1 : (exp_job.size() == 0 &&
         exposure_inhibit === 1'b0 && exposure_enable === 1'b0)));
      if (k >= 600)
         chk_val("wait", 32'h0, 32'h1);
   endtask : wt
   task automatic sense;
      xray_sense_in <= 1'b1;
      repeat (4) @(posedge mclk);
      xray_sense_in <= 1'b0;
   endtask : sense
   // jobs expected from acquisition onward
   task automatic after_acq(input logic [31:0] c);
      exp_job.push_back(ESC_JOB_ACQ);
      if (c[1:0] == 2'h2 && (c[3] || c[4]))
         exp_job.push_back(ESC_JOB_OFFSET);
      if (c[4] || c[1:0] == 2'h2)
         exp_job = {exp_job, ESC_JOB_XFER_PREVIEW, ESC_JOB_DARK, ESC_JOB_CORRECT,
            ESC_JOB_XFER_PROC};
      else
         exp_job.push_back(ESC_JOB_XFER_FINAL);
   endtask : after_acq
   // one exposure cycle; how: 0 normal, 1 abort, 2 timeout
   task automatic run(input logic [31:0] c, input int how);
      logic [31:0] e;
      e = (how == 1) ? 32'h20 : 32'h04;
      core_lat <= 4'($urandom % 16);
      prep_in <= !c[2];
      wr(ESC_OFS_CTRL, 32'h4);
      wr(ESC_OFS_CTRL, c);
      rd(ESC_OFS_IRQ_STAT, 32'h0, 32'h24);
      case (c[1:0])
         2'h1: begin
            exp_job = {ESC_JOB_PREP};
            prep_in <= c[2];
            wt(1'b1);
            after_acq(c);
            prep_in <= !c[2];
         end
         2'h2: begin
            after_acq(c);
            sense();
         end
         default: begin
            exp_job = {ESC_JOB_CLEAR};
            wr(ESC_OFS_CMD, 32'h1);
            wt(1'b1);
            rd(ESC_OFS_STATUS, 32'h20 | 32'(ESC_ST_WIN), 32'h3f);
            chk_val("irq", {31'h0, irq_on}, {31'h0, irq});
            rd(ESC_OFS_IRQ_STAT, 32'h3, 32'h3);
            chk_val("irq", 32'h0, {31'h0, irq});
            if (how == 1)
               wr(ESC_OFS_CMD, 32'h4);
            else begin
               after_acq(c);
               if (how == 0 && c[1:0] == 2'h3)
                  sense();
               else if (how == 0)
                  wr(ESC_OFS_CMD, 32'h2);
            end
         end
      endcase
      wt(1'b0);
      rd(ESC_OFS_STATUS, 32'(ESC_ST_IDLE), 32'h3f);
      if (how != 0)
         rd(ESC_OFS_IRQ_STAT, e, e);
      if (c[1:0] == 2'h2)
         rd(ESC_OFS_IRQ_STAT, 32'h3, 32'h3);
   endtask : run

   // watchdog against a hang
   initial begin
      repeat (40000) @(posedge mclk);
      chk_val("watchdog", 32'h0, 32'h1);
      report_and_stop();
   end

   // main sequence
   initial begin
      int r;
      void'($urandom(32'hae71b6f3));
      nrst = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      prep_in = 1'b0;
      xray_sense_in = 1'b0;
      core_lat = 4'h0;
      irq_on = 1'b1;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      rd(ESC_OFS_CTRL, 32'h4, 32'hffffffff);
      rd(ESC_OFS_CMD, 32'h0, 32'hffffffff);
      rd(5'h14, 32'h0, 32'hffffffff);
      bus(ESC_OFS_IRQ_MASK, 1'b1, 32'h3f, 4'h0);
      rd(ESC_OFS_IRQ_MASK, 32'h0, 32'hffffffff);
      r = $urandom;
      wr(ESC_OFS_IRQ_MASK, 32'(r));
      rd(ESC_OFS_IRQ_MASK, 32'(r) & 32'h3f, 32'hffffffff);
      wr(ESC_OFS_IRQ_MASK, 32'h3f);
      run(32'h6c, 0);
      run(32'h14, 0);
      for (int i = 0; i < 2; i++)
         run(32'h1 | 32'(i * 4), 0);
      run(32'h0a, 0);
      run(32'h02, 0);
      run(32'h07, 0);
      run(32'h04, 1);
      run(32'h04, 2);
      wr(ESC_OFS_IRQ_MASK, 32'h0);
      irq_on = 1'b0;
      run(32'h04, 0);
      report_and_stop();
   end
endmodule : tb_esc_top
